// File: hw/ubf_pkg.sv
// Constants, register map and types for the serial baud and receive FIFO core.
// Assumes one 25 MHz system clock and an APB register port.
// Overview of operation
// - One 8-bit data register; writes send a byte, reads return received byte.
// - Divisor is high byte and low byte; rate is clock over divisor plus frac/8.
// - Bits are timed by a 16-bit timer set by divisor and fractional field.
// - Frac field is added every bit; a carry into bit 3 adds one cycle.
// - Frac field sits in bits 5..3 of rate/FIFO control, used by both directions.
// - Samples at half, half+1, half+2 (range 0) or half-1, half, half+2 (range 1).
// - Trigger field picks fill for receive-available: 00=4, 01=1, 10=2, 11=3.
// - Receive FIFO is empty after reset.
// - Fill count rises on an accepted byte, falls on a software data read of a non-empty FIFO, and holds when both come in one cycle.
// - FIFO holds four; fifth waits in hold register, sixth replaces it.
// - Fill count clears on reset and while the unit enable is clear.
// - Fill count register is read-only, count in bits 2..0, rest zero.
// - With receive irq enable and its mask bit set, overrun or receive-available raise the request.
// - Disabling empties the FIFO and count, keeping divisor and control settings.
package ubf_pkg;
  localparam int CLK_HZ = 25000000;
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_DIVH = 12'h004;
  localparam logic [11:0] OFS_DIVL = 12'h008;
  localparam logic [11:0] OFS_RFC = 12'h00c;
  localparam logic [11:0] OFS_CNT = 12'h010;
  localparam logic [11:0] OFS_CTRL = 12'h014;
  localparam logic [11:0] OFS_STS = 12'h018;
  localparam logic [11:0] OFS_MASK = 12'h01c;
  localparam int RFC_FRAC_LSB = 3;
  localparam int RFC_RANGE_BIT = 2;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RIE_BIT = 1;
  localparam int STS_AVAIL_BIT = 0;
  localparam int STS_OVR_BIT = 1;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [5:0] RFC_RST = 6'h00;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam int MIN_DIV_RANGE0 = 16;
  localparam int MIN_DIV_RANGE1 = 8;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } ubf_rx_t;
endpackage

// File: hw/ubf_mem.sv
// Small byte memory for the receive FIFO, registered read data.
// Assumes the caller never writes and reads one entry in a way needing bypass.
`timescale 1ns/1ps
module ubf_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  localparam int AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rdata;
  } ubf_mem_st_t;
  ubf_mem_st_t s_q;
  ubf_mem_st_t s_d;

  if (WIDTH < 1 || DEPTH < 2) begin : g_bad
    $error("ubf_mem: WIDTH must be >= 1 and DEPTH >= 2");
  end

  always_comb begin
    s_d = s_q;
    if (we) begin
      s_d.mem[waddr] = wdata;
    end
    s_d.rdata = s_q.mem[raddr];
  end

  // Contents are left unreset on purpose
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rdata = s_q.rdata;
endmodule

// File: hw/ubf_baud.sv
// Bit timer with fractional modulation and three sample strobes per bit.
// Assumes start is a one-cycle pulse with run low in that cycle.
`timescale 1ns/1ps
module ubf_baud
  import ubf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic run,
  input wire logic [15:0] divisor,
  input wire logic [2:0] frac,
  input wire logic range_sel,
  // Strobes
  output logic bit_end,
  output logic samp,
  output logic samp_last
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0] acc;
    logic extra;
  } ubf_baud_st_t;
  ubf_baud_st_t s_q;
  ubf_baud_st_t s_d;
  logic [3:0] sum;
  logic [15:0] half;
  logic [15:0] last;
  logic [15:0] p0;
  logic [15:0] p1;
  logic [15:0] p2;

  always_comb begin
    sum = {1'b0, s_q.acc} + {1'b0, frac};
    half = divisor >> 1;
    last = divisor - 16'h1 + {15'h0, s_q.extra};
    p0 = range_sel ? half - 16'h1 : half;
    p1 = range_sel ? half : half + 16'h1;
    p2 = half + 16'h2;
    bit_end = run && (s_q.cnt == last);
    samp = run && (s_q.cnt == p0 || s_q.cnt == p1 || s_q.cnt == p2);
    samp_last = run && (s_q.cnt == p2);
    s_d = s_q;
    if (start) begin
      // Start bit counts as the first addition onto a cleared accumulator
      s_d.cnt = 16'h0;
      s_d.acc = frac;
      s_d.extra = 1'b0;
    end else if (!run) begin
      s_d.cnt = 16'h0;
    end else if (bit_end) begin
      s_d.cnt = 16'h0;
      s_d.acc = sum[2:0];
      s_d.extra = sum[3];
    end else begin
      s_d.cnt = s_q.cnt + 16'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  acc_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    start |=> (s_q.acc == $past(frac)) && !s_q.extra) else $error("accumulator not cleared at start");
  extra_cycle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (bit_end && !start) |=> s_q.extra == ($past({1'b0, s_q.acc}) + $past({1'b0, frac}) > 4'h7))
    else $error("extra cycle does not follow carry");
  first_samp_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (samp && !samp_last) |-> s_q.cnt >= (divisor >> 1) - {15'h0, range_sel}) else $error("sample too early");
endmodule

// File: hw/ubf_top.sv
// Serial port baud generator, receiver with four-byte FIFO and simple transmitter.
// Assumes an APB master on sys_clk; serial_in_pin is asynchronous.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module ubf_top
  import ubf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  localparam int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    logic [2:0] sync;
    logic rx_lvl;
    logic [7:0] div_hi;
    logic [7:0] div_lo;
    logic [15:0] div_act;
    logic [5:0] rfc;
    logic en;
    logic rie;
    logic [1:0] sts;
    logic [1:0] mask;
    logic avail_prev;
    logic ack;
    logic [31:0] prdata;
    ubf_rx_t rx_st;
    logic [3:0] rx_bit;
    logic [1:0] votes;
    logic [7:0] rx_sh;
    logic [7:0] hold;
    logic hold_v;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [2:0] fill;
    logic [7:0] tx_buf;
    logic tx_full;
    logic tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_out;
  } ubf_top_st_t;

  localparam ubf_top_st_t ST_RST = '{
    sync: 3'h7, rx_lvl: 1'b1, div_hi: DIV_RST, div_lo: DIV_RST,
    rfc: RFC_RST, rx_st: RX_IDLE, tx_out: 1'b1, default: '0
  };

  ubf_top_st_t s_q;
  ubf_top_st_t s_d;
  logic acc;
  logic wr_go;
  logic rd_go;
  logic hit;
  logic [31:0] rd_val;
  logic [7:0] mem_rdata;
  logic [7:0] mem_wdata;
  logic push;
  logic pop;
  logic space;
  logic rx_done;
  logic rx_start;
  logic rx_samp;
  logic rx_last;
  logic maj;
  logic avail;
  logic [2:0] need;
  logic tx_load;
  logic tx_end;
  logic [1:0] sts_clr;
  logic [1:0] sts_set;

  if (DEPTH != 2 && DEPTH != 4) begin : g_bad
    $error("ubf_top: DEPTH must be 2 or 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timers and FIFO storage

  ubf_baud u_rx_baud (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(rx_start),
    .run(s_q.rx_st != RX_IDLE),
    .divisor(s_q.div_act),
    .frac(s_q.rfc[RFC_FRAC_LSB +: 3]),
    .range_sel(s_q.rfc[RFC_RANGE_BIT]),
    .bit_end(),
    .samp(rx_samp),
    .samp_last(rx_last)
  );

  ubf_baud u_tx_baud (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(tx_load),
    .run(s_q.tx_busy),
    .divisor(s_q.div_act),
    .frac(s_q.rfc[RFC_FRAC_LSB +: 3]),
    .range_sel(s_q.rfc[RFC_RANGE_BIT]),
    .bit_end(tx_end),
    .samp(),
    .samp_last()
  );

  ubf_mem #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk(sys_clk),
    .we(push),
    .waddr(s_q.wptr),
    .wdata(mem_wdata),
    .raddr(s_q.rptr),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0;
    if (paddr == OFS_DATA) begin
      rd_val = {24'h0, mem_rdata};
    end else if (paddr == OFS_DIVH) begin
      rd_val = {24'h0, s_q.div_hi};
    end else if (paddr == OFS_DIVL) begin
      rd_val = {24'h0, s_q.div_lo};
    end else if (paddr == OFS_RFC) begin
      rd_val = {26'h0, s_q.rfc};
    end else if (paddr == OFS_CNT) begin
      rd_val = {29'h0, s_q.fill};
    end else if (paddr == OFS_CTRL) begin
      rd_val = {30'h0, s_q.rie, s_q.en};
    end else if (paddr == OFS_STS) begin
      rd_val = {30'h0, s_q.sts};
    end else if (paddr == OFS_MASK) begin
      rd_val = {30'h0, s_q.mask};
    end else begin
      hit = 1'b0;
    end
  end

  assign acc = psel && penable;
  assign pready = acc && s_q.ack;
  assign pslverr = pready && !hit;
  assign wr_go = pready && pwrite && hit;
  assign rd_go = pready && !pwrite && hit;
  assign prdata = s_q.prdata;
  assign serial_out_pin = s_q.tx_out;
  assign irq = s_q.rie && |(s_q.sts & s_q.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.ack = acc && !s_q.ack;
    if (acc && !s_q.ack) begin
      s_d.prdata = hit ? rd_val : 32'h0;
    end

    // Input synchroniser; a level change counts once stages two and three agree
    s_d.sync = {s_q.sync[1:0], serial_in_pin};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.rx_lvl = s_q.sync[2];
    end

    sts_clr = 2'h0;
    if (wr_go) begin
      if (paddr == OFS_DATA) begin
        s_d.tx_buf = pwdata[7:0];
        s_d.tx_full = s_q.en;
      end else if (paddr == OFS_DIVH) begin
        // Divisor takes effect on the high byte write
        s_d.div_hi = pwdata[7:0];
        s_d.div_act = {pwdata[7:0], s_q.div_lo};
      end else if (paddr == OFS_DIVL) begin
        s_d.div_lo = pwdata[7:0];
      end else if (paddr == OFS_RFC) begin
        s_d.rfc = pwdata[5:0];
      end else if (paddr == OFS_CTRL) begin
        s_d.en = pwdata[CTRL_EN_BIT];
        s_d.rie = pwdata[CTRL_RIE_BIT];
      end else if (paddr == OFS_STS) begin
        sts_clr = pwdata[1:0];
      end else if (paddr == OFS_MASK) begin
        s_d.mask = pwdata[1:0];
      end
    end

    // Receiver
    rx_start = 1'b0;
    rx_done = 1'b0;
    maj = (s_q.votes + {1'b0, s_q.rx_lvl}) >= 2'h2;
    case (s_q.rx_st)
      RX_IDLE: begin
        if (s_q.en && !s_q.rx_lvl) begin
          rx_start = 1'b1;
          s_d.rx_st = RX_START;
          s_d.votes = 2'h0;
          s_d.rx_bit = 4'h0;
        end
      end
      RX_START, RX_DATA, RX_STOP: begin
        if (rx_samp && !rx_last) begin
          s_d.votes = s_q.votes + {1'b0, s_q.rx_lvl};
        end else if (rx_last) begin
          s_d.votes = 2'h0;
          case (s_q.rx_st)
            RX_START: begin
              s_d.rx_st = maj ? RX_IDLE : RX_DATA;
            end
            RX_DATA: begin
              s_d.rx_sh = {maj, s_q.rx_sh[7:1]};
              s_d.rx_bit = s_q.rx_bit + 4'h1;
              if (s_q.rx_bit == DATA_LAST) begin
                s_d.rx_st = RX_STOP;
              end
            end
            default: begin
              rx_done = maj;
              s_d.rx_st = RX_IDLE;
            end
          endcase
        end
      end
      default: begin
        s_d.rx_st = RX_IDLE;
      end
    endcase

    // Receive FIFO with one-byte overflow hold
    pop = rd_go && (paddr == OFS_DATA) && (s_q.fill != 3'h0);
    space = (s_q.fill < 3'(DEPTH)) || pop;
    push = space && (s_q.hold_v || rx_done);
    mem_wdata = s_q.hold_v ? s_q.hold : s_q.rx_sh;
    sts_set = 2'h0;
    if (rx_done && (s_q.hold_v || !space)) begin
      sts_set[STS_OVR_BIT] = s_q.hold_v && !push;
      s_d.hold = s_q.rx_sh;
      s_d.hold_v = 1'b1;
    end else if (push && s_q.hold_v) begin
      s_d.hold_v = 1'b0;
    end
    s_d.fill = s_q.fill + {2'h0, push} - {2'h0, pop};
    s_d.wptr = s_q.wptr + AW'(push);
    s_d.rptr = s_q.rptr + AW'(pop);

    need = (s_q.rfc[1:0] == 2'h0) ? 3'(DEPTH) : {1'b0, s_q.rfc[1:0]};
    avail = s_q.fill >= need;
    s_d.avail_prev = avail;
    sts_set[STS_AVAIL_BIT] = avail && !s_q.avail_prev;
    s_d.sts = (s_q.sts & ~sts_clr) | sts_set;

    // Transmitter, one start bit, eight data bits, one stop bit
    tx_load = s_q.en && !s_q.tx_busy && s_q.tx_full;
    if (tx_load) begin
      s_d.tx_sh = {1'b1, s_q.tx_buf, 1'b0};
      s_d.tx_cnt = 4'h0;
      s_d.tx_busy = 1'b1;
      s_d.tx_full = 1'b0;
    end else if (s_q.tx_busy && tx_end) begin
      s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
      s_d.tx_cnt = s_q.tx_cnt + 4'h1;
      s_d.tx_busy = s_q.tx_cnt != FRAME_LAST;
    end
    s_d.tx_out = s_d.tx_busy ? s_d.tx_sh[0] : 1'b1;

    // Disabled unit: flush buffers and flags, keep rate settings
    if (!s_q.en) begin
      s_d.fill = 3'h0;
      s_d.wptr = '0;
      s_d.rptr = '0;
      s_d.hold_v = 1'b0;
      s_d.sts = 2'h0;
      s_d.avail_prev = 1'b0;
      s_d.rx_st = RX_IDLE;
      s_d.tx_busy = 1'b0;
      s_d.tx_full = 1'b0;
      s_d.tx_out = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  fill_max_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_q.fill <= 3'(DEPTH)) else $error("fill count above depth");
  fill_inc_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_q.en && push && !pop) |=> s_q.fill == $past(s_q.fill) + 3'h1) else $error("fill did not rise");
  fill_dec_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_q.en && pop && !push) |=> s_q.fill == $past(s_q.fill) - 3'h1) else $error("fill did not fall");
  dis_flush_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!s_q.en && !$past(wr_go)) |-> s_q.fill == 3'h0 && !s_q.hold_v && s_q.sts == 2'h0)
    else $error("disabled unit holds data");
  en_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(s_q.en) |-> s_q.fill == 3'h0) else $error("fill not clear at enable");
  cnt_ro_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pready && !pwrite && paddr == OFS_CNT) |-> prdata[31:3] == 29'h0 && prdata[2:0] == $past(s_q.fill))
    else $error("fill count read wrong");
  trig_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_q.en && avail && !s_q.avail_prev) |=> s_q.sts[STS_AVAIL_BIT]) else $error("available flag missed");
  ovr_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_q.en && rx_done && s_q.hold_v && !push) |=> s_q.sts[STS_OVR_BIT] && s_q.fill == 3'(DEPTH))
    else $error("overrun not flagged");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !s_q.rie |-> !irq) else $error("interrupt without enable");
  div_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (wr_go && paddr == OFS_DIVH) |=> s_q.div_act == {$past(pwdata[7:0]), s_q.div_lo})
    else $error("divisor not loaded");
  tx_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_load |=> !serial_out_pin ##1 !serial_out_pin) else $error("no start bit");

  rx_byte_c: cover property (@(posedge sys_clk) disable iff (!arst_n) push);
  overrun_c: cover property (@(posedge sys_clk) disable iff (!arst_n) sts_set[STS_OVR_BIT]);
  irq_c: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(irq));
  tx_done_c: cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(s_q.tx_busy));
endmodule

// File: testbench/ubf_peer.sv
// Remote serial peer: sends 8N1 frames into the receiver and captures transmitted bytes.
// Assumes the bench sets div_v and frac_v to the values it programs into the block.
`timescale 1ns/1ps
module ubf_peer (
  // Clock
  input wire logic sys_clk,
  // Serial lines
  input wire logic serial_out_pin,
  output logic serial_in_pin
);
  logic [15:0] div_v = 16'h0010;
  logic [2:0] frac_v = 3'h0;
  logic [7:0] rx_q[$];
  logic [7:0] end_q[$];

  // Length of bit k of a frame, accumulator restarting at the start bit
  function automatic int bit_len(input int k);
    return int'(div_v) + int'(((frac_v * (k + 1)) >> 3) != ((frac_v * k) >> 3));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line idles high between frames
  initial serial_in_pin = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      serial_in_pin <= fr[k];
      repeat (bit_len(k)) @(posedge sys_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Samples each transmitted bit in its first and its last cycle; a bit one cycle off shows as a mismatch when its neighbouring bit differs
  initial begin
    logic [9:0] head_s;
    logic [9:0] tail_s;
    forever begin
      @(negedge serial_out_pin);
      for (int k = 0; k < 10; k++) begin
        @(posedge sys_clk);
        head_s[k] = serial_out_pin;
        repeat (bit_len(k) - 1) @(posedge sys_clk);
        tail_s[k] = serial_out_pin;
      end
      rx_q.push_back(head_s[8:1]);
      end_q.push_back(tail_s[8:1]);
    end
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the serial baud and receive FIFO core.
// Assumes the APB map and timing of ubf_pkg and a serial peer model.
`timescale 1ns/1ps
module tb;
  import ubf_pkg::*;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, serial_in_pin, serial_out_pin, irq, err_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, seed;
  int miscompares, check_count, cycles;
  logic [7:0] exp_q[$];
  logic [7:0] b;
  logic [11:0] ofs[7] = '{OFS_DIVH, OFS_DIVL, OFS_RFC, OFS_CNT, OFS_CTRL, OFS_STS, OFS_MASK};
  logic [15:0] dv[3] = '{16'h0010, 16'h0008, 16'h0014};
  logic [2:0] fr[3] = '{3'h3, 3'h5, 3'h7};
  logic rg[3] = '{1'b0, 1'b1, 1'b0};

  ubf_top i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .irq(irq));
  ubf_peer i_peer (.sys_clk(sys_clk), .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin));

  always #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares = miscompares + 1;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // Fill level at which the receive-available flag sets
  function automatic int thr(input logic [1:0] t);
    return (t == 2'h0) ? 4 : int'(t);
  endfunction

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, then one idle cycle so results have settled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic cfg(input logic [15:0] d, input logic [2:0] f, input logic r, input logic [1:0] t);
    apb(1'b1, OFS_DIVL, {24'h0, d[7:0]});
    apb(1'b1, OFS_DIVH, {24'h0, d[15:8]});
    apb(1'b1, OFS_RFC, {26'h0, f, r, t});
    i_peer.div_v = d;
    i_peer.frac_v = f;
  endtask

  task automatic rx(input logic [7:0] v);
    i_peer.send_byte(v);
    exp_q.push_back(v);
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic pop(input int left);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd_v, {24'h0, exp_q.pop_front()});
    apb(1'b0, OFS_CNT, 32'h0);
    chk(rd_v, left);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    seed = 32'hf7972938;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd_v, 32'h0);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err_v}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b1, OFS_MASK, 32'h3);
    for (int t = 0; t < 4; t++) begin
      cfg(16'h0010, 3'h3, 1'b0, t[1:0]);
      apb(1'b1, OFS_STS, 32'h3);
      for (int n = 1; n <= 4; n++) begin
        rx(rnd());
        apb(1'b0, OFS_STS, 32'h0);
        chk(rd_v, {31'h0, n >= thr(t[1:0])});
        chk({31'h0, irq}, {31'h0, n >= thr(t[1:0])});
        apb(1'b0, OFS_CNT, 32'h0);
        chk(rd_v, n);
      end
      for (int n = 3; n >= 0; n--) pop(n);
    end
    // Overflow: fifth byte held, sixth replaces it
    cfg(16'h0008, 3'h5, 1'b1, 2'h1);
    for (int n = 0; n < 6; n++) rx(rnd());
    exp_q.delete(4);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(rd_v, 32'h4);
    apb(1'b0, OFS_STS, 32'h0);
    chk(rd_v, 32'h3);
    apb(1'b1, OFS_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_MASK, 32'h3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_STS, 32'h3);
    chk({31'h0, irq}, 32'h0);
    for (int n = 4; n >= 0; n--) pop(n);
    // Rate configurations in both directions
    for (int c = 0; c < 3; c++) begin
      cfg(dv[c], fr[c], rg[c], 2'h1);
      b = rnd();
      apb(1'b1, OFS_DATA, {24'h0, b});
      while (i_peer.rx_q.size() == 0) @(posedge sys_clk);
      chk({24'h0, i_peer.rx_q.pop_front()}, {24'h0, b});
      chk({24'h0, i_peer.end_q.pop_front()}, {24'h0, b});
      rx(rnd());
      rx(rnd());
      apb(1'b1, OFS_CNT, 32'h7);
      apb(1'b0, OFS_CNT, 32'h0);
      chk(rd_v, 32'h2);
      pop(1);
      pop(0);
    end
    // Disable discards data but keeps settings
    rx(rnd());
    rx(rnd());
    apb(1'b1, OFS_CTRL, 32'h2);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b0, OFS_DIVL, 32'h0);
    chk(rd_v, {24'h0, dv[2][7:0]});
    apb(1'b0, OFS_RFC, 32'h0);
    chk(rd_v, {26'h0, fr[2], rg[2], 2'h1});
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(rd_v, 32'h0);
    exp_q.delete();
    rx(rnd());
    pop(0);
    print_verdict();
  end
endmodule
